// [rtl/fbs_pkg.sv]
/*
 * Shared constants and types of the flash block-erase host controller.
 * Assumes a 40 MHz core clock and a byte-wide flash on the far side.
 */
package fbs_pkg;
	// Clock period and pin timing, in ns
	localparam int CLK_PERIOD_NS = 25;
	localparam int T_WE_NS       = 50;   // Write strobe width
	localparam int T_ACC_NS      = 100;  // Read access time
	localparam int T_GAP_NS      = 50;   // Deselect time between cycles
	// Cycle counts: least times round up
	localparam int WE_CYC  = (T_WE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GAP_CYC = (T_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_W  = 21;         // 16 Mbit byte-wide span
	// Flash command bytes
	localparam logic [7:0] CMD_ERASE_SETUP   = 8'h20;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hD0;
	localparam logic [7:0] CMD_READ_ARRAY    = 8'hFF;
	// Flash status byte bit positions
	localparam int ST_ENGINE_READY = 7;
	localparam int ST_ERASE_FAIL   = 5;
	localparam int ST_PROG_FAIL    = 4;
	localparam int ST_VOLT_LOW     = 3;
	localparam int ST_LOCKED       = 1;
	localparam logic [7:0] ST_ERR_MASK = 8'h3A;
	// Register offsets (byte addresses)
	localparam logic [7:0] OFF_CTRL     = 8'h00;
	localparam logic [7:0] OFF_ADDR     = 8'h04;
	localparam logic [7:0] OFF_DATA     = 8'h08;
	localparam logic [7:0] OFF_DEV_STAT = 8'h0C;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFF_IRQ_CLR  = 8'h14;
	localparam logic [7:0] OFF_IRQ_EN   = 8'h18;
	localparam logic [7:0] OFF_ERR_ACC  = 8'h1C;
	// Control fields
	localparam int CTRL_CHECK_EACH = 3;
	localparam logic [2:0] OP_ERASE      = 3'h1;
	localparam logic [2:0] OP_READ_ARRAY = 3'h2;
	localparam logic [2:0] OP_RAW_WRITE  = 3'h3;
	localparam logic [2:0] OP_READ       = 3'h4;
	localparam logic [2:0] OP_READ_STAT  = 3'h5;
	// Interrupt event bits
	localparam int IRQ_DONE    = 0;
	localparam int IRQ_ERROR   = 1;
	localparam int IRQ_REFUSED = 2;
	localparam int IRQ_W       = 3;
	// Reset values and bus response codes
	localparam logic [7:0] DEV_STAT_RST = 8'h80;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	// Sequencer and pin engine states
	typedef enum logic [2:0] {
		SEQ_IDLE, SEQ_SETUP, SEQ_CONFIRM, SEQ_POLL, SEQ_CMD_WR, SEQ_RD
	} fbs_seq_state_type;
	typedef enum logic [1:0] {
		CYC_IDLE, CYC_ACT, CYC_HOLD, CYC_GAP
	} fbs_cyc_state_type;
endpackage : fbs_pkg

// [rtl/fbs_cyc_if.sv]
/*
 * Request and answer bundle between sequencer and flash pin engine.
 * Assumes req is a one-cycle pulse and payload stays until done.
 */
`timescale 1ns/100ps
interface fbs_cyc_if;
	logic                      req;    // One-cycle start pulse
	logic                      wr;     // 1 write, 0 read
	logic [fbs_pkg::ADDR_W-1:0] addr;  // Flash byte address
	logic [7:0]                wdata;  // Byte to write
	logic [7:0]                rdata;  // Byte read back
	logic                      done;   // One-cycle end pulse
	modport seq (output req, wr, addr, wdata, input rdata, done);
	modport eng (input req, wr, addr, wdata, output rdata, done);
endinterface : fbs_cyc_if

// [rtl/fbs_cycle.sv]
/*
 * Flash pin engine: runs one asynchronous write or read bus cycle.
 * Assumes the flash pins are sampled synchronously to core_clk.
 */
`timescale 1ns/100ps
module fbs_cycle (
	input  wire logic                       core_clk,
	input  wire logic                       reset,
	fbs_cyc_if.eng                          cyc,
	output logic [fbs_pkg::ADDR_W-1:0]      flash_addr,
	output logic                            flash_ce_n,
	output logic                            flash_oe_n,
	output logic                            flash_we_n,
	output logic [7:0]                      flash_dq_out,
	output logic                            flash_dq_oe,
	input  wire logic [7:0]                 flash_dq_in
);
	fbs_pkg::fbs_cyc_state_type state_reg;  // Engine phase
	logic [3:0]                 cnt_reg;    // Phase countdown
	logic                       done_reg;   // End pulse
	logic [7:0]                 rdata_reg;  // Captured read byte

	assign cyc.done  = done_reg;
	assign cyc.rdata = rdata_reg;

	// Pin sequencing; data stays driven one cycle past the strobe for hold
	always_ff @(posedge core_clk) begin
		done_reg <= 1'b0;
		if (reset) begin
			state_reg    <= fbs_pkg::CYC_IDLE;
			cnt_reg      <= 4'h0;
			flash_addr   <= '0;
			flash_ce_n   <= 1'b1;
			flash_oe_n   <= 1'b1;
			flash_we_n   <= 1'b1;
			flash_dq_out <= 8'h00;
			flash_dq_oe  <= 1'b0;
			rdata_reg    <= 8'h00;
		end else begin
			case (state_reg)
				// Take a request and assert strobes
				fbs_pkg::CYC_IDLE: if (cyc.req) begin
					flash_addr   <= cyc.addr;
					flash_dq_out <= cyc.wdata;
					flash_ce_n   <= 1'b0;
					flash_we_n   <= ~cyc.wr;
					flash_oe_n   <= cyc.wr;
					flash_dq_oe  <= cyc.wr;
					cnt_reg      <= cyc.wr ? 4'(fbs_pkg::WE_CYC - 1) : 4'(fbs_pkg::ACC_CYC - 1);
					state_reg    <= fbs_pkg::CYC_ACT;
				end
				// Strobe active
				fbs_pkg::CYC_ACT: if (cnt_reg != 4'h0) begin
					cnt_reg <= cnt_reg - 4'h1;
				end else if (!flash_we_n) begin
					flash_we_n <= 1'b1;
					state_reg  <= fbs_pkg::CYC_HOLD;
				end else begin
					rdata_reg  <= flash_dq_in;
					flash_oe_n <= 1'b1;
					flash_ce_n <= 1'b1;
					cnt_reg    <= 4'(fbs_pkg::GAP_CYC - 1);
					state_reg  <= fbs_pkg::CYC_GAP;
				end
				// Data hold after write strobe
				fbs_pkg::CYC_HOLD: begin
					flash_ce_n  <= 1'b1;
					flash_dq_oe <= 1'b0;
					cnt_reg     <= 4'(fbs_pkg::GAP_CYC - 1);
					state_reg   <= fbs_pkg::CYC_GAP;
				end
				// Deselected gap so the next read sees fresh status
				fbs_pkg::CYC_GAP: if (cnt_reg != 4'h0) begin
					cnt_reg <= cnt_reg - 4'h1;
				end else begin
					done_reg  <= 1'b1;
					state_reg <= fbs_pkg::CYC_IDLE;
				end
				default: state_reg <= fbs_pkg::CYC_IDLE;
			endcase
		end
	end

	gap_deselect_a: assert property (@(posedge core_clk) disable iff (reset)
		state_reg == fbs_pkg::CYC_GAP |-> flash_ce_n && flash_oe_n && flash_we_n)
		else $error("Pins not released in gap");
	no_contention_a: assert property (@(posedge core_clk) disable iff (reset)
		!(flash_dq_oe && !flash_oe_n))
		else $error("Data driven while output enabled");
	read_toggle_a: assert property (@(posedge core_clk) disable iff (reset)
		$fell(flash_oe_n) |-> (!flash_oe_n)[*4] ##1 flash_oe_n[*3])
		else $error("Output enable not toggled between reads");
endmodule : fbs_cycle

// [rtl/fbs_ctrl.sv]
/*
 * Host-side flash block-erase controller with AXI4-Lite registers.
 * Assumes one byte-wide flash on the pins and a single core clock.
 */
// Implementation choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module fbs_ctrl (
	input  wire logic                  core_clk,
	input  wire logic                  reset,
	input  wire logic [7:0]            s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [7:0]            s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	output logic                       irq,
	output logic [fbs_pkg::ADDR_W-1:0] flash_addr,
	output logic                       flash_ce_n,
	output logic                       flash_oe_n,
	output logic                       flash_we_n,
	output logic [7:0]                 flash_dq_out,
	output logic                       flash_dq_oe,
	input  wire logic [7:0]            flash_dq_in
);
	// Bus slave state
	logic [7:0]                 awaddr_reg;    // Held write address
	logic                       aw_held_reg;   // Write address taken
	logic [31:0]                wdata_reg;     // Held write data
	logic [3:0]                 wstrb_reg;     // Held byte enables
	logic                       w_held_reg;    // Write data taken
	logic                       bvalid_reg;    // Write answer pending
	logic [1:0]                 bresp_reg;     // Write answer code
	logic                       rvalid_reg;    // Read answer pending
	logic [31:0]                rdata_reg;     // Read answer data
	logic [1:0]                 rresp_reg;     // Read answer code
	logic                       wr_fire;       // Write applied this cycle
	logic [31:0]                wmask;         // Byte lanes as bit mask
	logic                       wr_map;        // Write hits a writable register
	// Software-visible registers and the event strobes that set them
	logic [fbs_pkg::ADDR_W-1:0] addr_reg;      // Target flash address
	logic [7:0]                 data_reg;      // Raw write / read result
	logic                       check_each_reg;// Check flags per erase
	logic [7:0]                 dev_stat_reg;  // Last status byte seen
	logic [7:0]                 err_acc_reg;   // Accumulated error flags
	logic [fbs_pkg::IRQ_W-1:0]  irq_stat_reg;  // Sticky events
	logic [fbs_pkg::IRQ_W-1:0]  irq_en_reg;    // Event enables
	logic [fbs_pkg::IRQ_W-1:0]  irq_set;       // Events this cycle
	logic [7:0]                 err_acc_set;   // Flags to accumulate
	// Sequencer state
	fbs_pkg::fbs_seq_state_type seq_reg;       // Operation step
	logic [2:0]                 op_reg;        // Operation in progress
	logic                       issued_reg;    // Cycle under way
	logic                       start;         // Software start strobe
	logic [2:0]                 start_op;      // Requested operation
	logic                       flags_block;   // Retry must wait
	logic                       req_reg;       // Cycle request pulse
	logic                       cwr_reg;       // Cycle direction
	logic [7:0]                 cwdata_reg;    // Cycle write byte

	fbs_cyc_if cyc ();

	assign cyc.req   = req_reg;
	assign cyc.wr    = cwr_reg;
	assign cyc.addr  = addr_reg;
	assign cyc.wdata = cwdata_reg;

	// Handshake outputs
	assign s_axi_awready = !aw_held_reg && !bvalid_reg;
	assign s_axi_wready  = !w_held_reg && !bvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	// A write is applied once both halves have arrived
	assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
	assign wmask   = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}}, {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
	assign wr_map  = awaddr_reg[7:5] == 3'h0 && awaddr_reg[1:0] == 2'h0 &&
		awaddr_reg != fbs_pkg::OFF_DEV_STAT && awaddr_reg != fbs_pkg::OFF_IRQ_STAT;
	assign start    = wr_fire && awaddr_reg == fbs_pkg::OFF_CTRL && wstrb_reg[0];
	assign start_op = wdata_reg[2:0];

	// stale locked or voltage flags hold off erase
	assign flags_block = dev_stat_reg[fbs_pkg::ST_LOCKED] | dev_stat_reg[fbs_pkg::ST_VOLT_LOW];

	// Write channel capture and answer
	always_ff @(posedge core_clk) begin
		if (reset) begin
			aw_held_reg <= 1'b0;
			w_held_reg  <= 1'b0;
			awaddr_reg  <= 8'h00;
			wdata_reg   <= 32'h00000000;
			wstrb_reg   <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= fbs_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_reg  <= s_axi_awaddr;
				aw_held_reg <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_reg  <= s_axi_wdata;
				wstrb_reg  <= s_axi_wstrb;
				w_held_reg <= 1'b1;
			end
			if (wr_fire) begin
				aw_held_reg <= 1'b0;
				w_held_reg  <= 1'b0;
				bvalid_reg  <= 1'b1;
				bresp_reg   <= wr_map ? fbs_pkg::RESP_OKAY : fbs_pkg::RESP_SLVERR;
			end else if (bvalid_reg && s_axi_bready) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Read channel; one read outstanding at a time
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h00000000;
			rresp_reg  <= fbs_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= fbs_pkg::RESP_OKAY;
			case (s_axi_araddr)
				fbs_pkg::OFF_CTRL:     rdata_reg <= {28'h0, check_each_reg,
					2'h0, seq_reg != fbs_pkg::SEQ_IDLE};
				fbs_pkg::OFF_ADDR:     rdata_reg <= {11'h0, addr_reg};
				fbs_pkg::OFF_DATA:     rdata_reg <= {24'h0, data_reg};
				fbs_pkg::OFF_DEV_STAT: rdata_reg <= {24'h0, dev_stat_reg};
				fbs_pkg::OFF_IRQ_STAT: rdata_reg <= {29'h0, irq_stat_reg};
				fbs_pkg::OFF_IRQ_CLR:  rdata_reg <= 32'h00000000;
				fbs_pkg::OFF_IRQ_EN:   rdata_reg <= {29'h0, irq_en_reg};
				fbs_pkg::OFF_ERR_ACC:  rdata_reg <= {24'h0, err_acc_reg};
				default: begin
					// Unmapped: zero data, slave error
					rdata_reg <= 32'h00000000;
					rresp_reg <= fbs_pkg::RESP_SLVERR;
				end
			endcase
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Plain software registers
	always_ff @(posedge core_clk) begin
		if (reset) begin
			addr_reg       <= '0;
			check_each_reg <= 1'b1;
			irq_en_reg     <= '0;
		end else if (wr_fire) begin
			case (awaddr_reg)
				fbs_pkg::OFF_ADDR: addr_reg <= fbs_pkg::ADDR_W'(({11'h0, addr_reg} & ~wmask) |
					(wdata_reg & wmask));
				fbs_pkg::OFF_IRQ_EN: if (wstrb_reg[0]) irq_en_reg <= wdata_reg[fbs_pkg::IRQ_W-1:0];
				fbs_pkg::OFF_CTRL: if (wstrb_reg[0] && seq_reg == fbs_pkg::SEQ_IDLE)
					check_each_reg <= wdata_reg[fbs_pkg::CTRL_CHECK_EACH];
				default: ;
			endcase
		end
	end

	// Interrupt status: set wins over a clear in the same cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq_stat_reg <= '0;
		end else if (wr_fire && awaddr_reg == fbs_pkg::OFF_IRQ_CLR && wstrb_reg[0]) begin
			irq_stat_reg <= (irq_stat_reg & ~wdata_reg[fbs_pkg::IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_reg <= irq_stat_reg | irq_set;
		end
	end
	assign irq = |(irq_stat_reg & irq_en_reg);

	// accumulated flags for a deferred check; write 1 to clear, set wins
	always_ff @(posedge core_clk) begin
		if (reset) begin
			err_acc_reg <= 8'h00;
		end else if (wr_fire && awaddr_reg == fbs_pkg::OFF_ERR_ACC && wstrb_reg[0]) begin
			err_acc_reg <= (err_acc_reg & ~wdata_reg[7:0]) | err_acc_set;
		end else begin
			err_acc_reg <= err_acc_reg | err_acc_set;
		end
	end

	// Operation sequencer; events and flag accumulation from here
	always_ff @(posedge core_clk) begin
		req_reg     <= 1'b0;
		irq_set     <= '0;
		err_acc_set <= 8'h00;
		if (reset) begin
			seq_reg      <= fbs_pkg::SEQ_IDLE;
			op_reg       <= 3'h0;
			issued_reg   <= 1'b0;
			cwr_reg      <= 1'b0;
			cwdata_reg   <= 8'h00;
			data_reg     <= 8'h00;
			dev_stat_reg <= fbs_pkg::DEV_STAT_RST;
		end else begin
			if (wr_fire && awaddr_reg == fbs_pkg::OFF_DATA && wstrb_reg[0])
				data_reg <= wdata_reg[7:0];
			case (seq_reg)
				// Wait for a start; unknown ops are refused
				fbs_pkg::SEQ_IDLE: if (start) begin
					op_reg     <= start_op;
					issued_reg <= 1'b0;
					case (start_op)
						fbs_pkg::OP_ERASE: begin
							if (flags_block)
								irq_set[fbs_pkg::IRQ_REFUSED] <= 1'b1;
							else
								seq_reg <= fbs_pkg::SEQ_SETUP;
						end
						fbs_pkg::OP_READ_ARRAY, fbs_pkg::OP_RAW_WRITE:
							seq_reg <= fbs_pkg::SEQ_CMD_WR;
						fbs_pkg::OP_READ, fbs_pkg::OP_READ_STAT:
							seq_reg <= fbs_pkg::SEQ_RD;
						default: irq_set[fbs_pkg::IRQ_REFUSED] <= 1'b1;
					endcase
				end
				// setup byte into the target block
				fbs_pkg::SEQ_SETUP: if (!issued_reg) begin
					req_reg    <= 1'b1;
					cwr_reg    <= 1'b1;
					cwdata_reg <= fbs_pkg::CMD_ERASE_SETUP;
					issued_reg <= 1'b1;
				end else if (cyc.done) begin
					issued_reg <= 1'b0;
					seq_reg    <= fbs_pkg::SEQ_CONFIRM;
				end
				// confirm byte at the same block address
				fbs_pkg::SEQ_CONFIRM: if (!issued_reg) begin
					req_reg    <= 1'b1;
					cwdata_reg <= fbs_pkg::CMD_ERASE_CONFIRM;
					issued_reg <= 1'b1;
				end else if (cyc.done) begin
					issued_reg <= 1'b0;
					seq_reg    <= fbs_pkg::SEQ_POLL;
				end
				// poll status until the engine reports ready
				fbs_pkg::SEQ_POLL: if (!issued_reg) begin
					req_reg    <= 1'b1;
					cwr_reg    <= 1'b0;
					issued_reg <= 1'b1;
				end else if (cyc.done) begin
					issued_reg   <= 1'b0;
					dev_stat_reg <= cyc.rdata;
					if (cyc.rdata[fbs_pkg::ST_ENGINE_READY]) begin
						// flag error now or leave it to a later check
						err_acc_set <= cyc.rdata & fbs_pkg::ST_ERR_MASK;
						irq_set[fbs_pkg::IRQ_DONE]  <= 1'b1;
						irq_set[fbs_pkg::IRQ_ERROR] <= check_each_reg &&
							|(cyc.rdata & fbs_pkg::ST_ERR_MASK);
						seq_reg <= fbs_pkg::SEQ_IDLE;
					end
				end
				// read-array byte, or a raw command byte
				fbs_pkg::SEQ_CMD_WR: if (!issued_reg) begin
					req_reg    <= 1'b1;
					cwr_reg    <= 1'b1;
					cwdata_reg <= (op_reg == fbs_pkg::OP_READ_ARRAY) ?
						fbs_pkg::CMD_READ_ARRAY : data_reg;
					issued_reg <= 1'b1;
				end else if (cyc.done) begin
					issued_reg <= 1'b0;
					irq_set[fbs_pkg::IRQ_DONE] <= 1'b1;
					seq_reg <= fbs_pkg::SEQ_IDLE;
				end
				// Single read; a status read also refreshes the copy
				fbs_pkg::SEQ_RD: if (!issued_reg) begin
					req_reg    <= 1'b1;
					cwr_reg    <= 1'b0;
					issued_reg <= 1'b1;
				end else if (cyc.done) begin
					issued_reg <= 1'b0;
					data_reg   <= cyc.rdata;
					if (op_reg == fbs_pkg::OP_READ_STAT)
						dev_stat_reg <= cyc.rdata;
					irq_set[fbs_pkg::IRQ_DONE] <= 1'b1;
					seq_reg <= fbs_pkg::SEQ_IDLE;
				end
				default: seq_reg <= fbs_pkg::SEQ_IDLE;
			endcase
		end
	end

	fbs_cycle u_cycle (
		.core_clk     (core_clk),
		.reset        (reset),
		.cyc          (cyc),
		.flash_addr   (flash_addr),
		.flash_ce_n   (flash_ce_n),
		.flash_oe_n   (flash_oe_n),
		.flash_we_n   (flash_we_n),
		.flash_dq_out (flash_dq_out),
		.flash_dq_oe  (flash_dq_oe),
		.flash_dq_in  (flash_dq_in)
	);

	sequence setup_issued_s;
		seq_reg == fbs_pkg::SEQ_SETUP && req_reg;
	endsequence
	sequence confirm_issued_s;
		seq_reg == fbs_pkg::SEQ_CONFIRM && req_reg && cwdata_reg == fbs_pkg::CMD_ERASE_CONFIRM;
	endsequence

	setup_byte_a: assert property (@(posedge core_clk) disable iff (reset)
		setup_issued_s |-> cwr_reg && cwdata_reg == fbs_pkg::CMD_ERASE_SETUP)
		else $error("Setup cycle without setup byte");
	// Setup write cycle plus done handover takes eight edges
	confirm_follows_a: assert property (@(posedge core_clk) disable iff (reset)
		setup_issued_s |-> ##[8:9] confirm_issued_s)
		else $error("Confirm did not follow setup");
	// Refused event is registered once before it reaches the sticky bit
	refuse_flags_a: assert property (@(posedge core_clk) disable iff (reset)
		seq_reg == fbs_pkg::SEQ_IDLE && start && start_op == fbs_pkg::OP_ERASE && flags_block
		|=> seq_reg == fbs_pkg::SEQ_IDLE ##1 irq_stat_reg[fbs_pkg::IRQ_REFUSED])
		else $error("Erase started with stale flags");
	read_array_a: assert property (@(posedge core_clk) disable iff (reset)
		seq_reg == fbs_pkg::SEQ_CMD_WR && req_reg && op_reg == fbs_pkg::OP_READ_ARRAY
		|-> cwr_reg && cwdata_reg == fbs_pkg::CMD_READ_ARRAY)
		else $error("Read-array byte wrong");
	acc_flags_a: assert property (@(posedge core_clk) disable iff (reset)
		seq_reg == fbs_pkg::SEQ_POLL && cyc.done && cyc.rdata[fbs_pkg::ST_ENGINE_READY]
		|-> ##2 (err_acc_reg & cyc.rdata[7:0] & fbs_pkg::ST_ERR_MASK) ==
		($past(cyc.rdata, 2) & fbs_pkg::ST_ERR_MASK))
		else $error("Error flags not accumulated");
endmodule : fbs_ctrl

// [tb/fbs_flash_model.sv]
/* Behavioural byte-wide flash: command decode, erase engine, status byte.
   Assumes the host moves the pins from one clock; dq has no pull. */
`timescale 1ns/100ps
module fbs_flash_model #(
	parameter logic [7:0] CLR_CMD = 8'h50 // Clear-status byte, value arbitrary
) (
	input  wire logic [20:0] flash_addr,
	input  wire logic        flash_ce_n,
	input  wire logic        flash_oe_n,
	input  wire logic        flash_we_n,
	input  wire logic [7:0]  flash_dq_out,
	input  wire logic        flash_dq_oe,
	output logic [7:0]       flash_dq_in,
	input  wire logic [5:0]  lock_num,  // Locked block number
	input  wire logic        volt_low,  // Supply out of range
	input  wire logic        erase_bad  // Erase fails
);
	logic [7:0]  sr = 8'h80;   // Status byte
	logic [7:0]  q = 8'h00;    // Byte of the current read
	logic [7:0]  last = 8'h00; // Last byte driven
	logic        stat_mode = 1'h0;
	logic        setup = 1'h0;
	logic [38:0] erased = '0;  // One flag per block
	int          busy = 0;     // Status reads left while erasing
	function automatic logic [5:0] blk(input logic [20:0] a);
		return (a < 21'h10000) ? {3'h0, a[15:13]} : {1'h0, a[20:16]} + 6'h07;
	endfunction : blk
	always @(posedge flash_we_n) begin
		if (!flash_ce_n && setup) begin
			setup = 1'h0;
			if (flash_dq_out !== 8'hD0)
				sr[5:4] = 2'h3;
			else if (!sr[1] && !sr[3]) begin
				if (blk(flash_addr) == lock_num)
					sr[1] = 1'h1;
				else if (volt_low)
					sr[3] = 1'h1;
				else begin
					busy = 3;
					sr[7] = 1'h0;
					if (erase_bad)
						sr[5] = 1'h1;
					else
						erased[blk(flash_addr)] = 1'h1;
				end
			end
		end else if (!flash_ce_n) begin
			setup = (flash_dq_out == 8'h20);
			if (flash_dq_out == 8'hFF)
				stat_mode = 1'h0;
			if (flash_dq_out == 8'h20)
				stat_mode = 1'h1;
			if (flash_dq_out == CLR_CMD)
				sr = sr & 8'hC5;
		end
	end
	// status refreshed only at a read start
	always @(negedge (flash_ce_n | flash_oe_n)) begin
		if (busy > 0)
			busy = busy - 1;
		if (busy == 0)
			sr[7] = 1'h1;
		q = stat_mode ? sr : (erased[blk(flash_addr)] ? 8'hFF : 8'h00);
	end
	always @(posedge (flash_ce_n | flash_oe_n))
		last = q;
	// Released bus shows the inverse, so stale data never matches
	assign flash_dq_in = (!flash_ce_n && !flash_oe_n) ? q : (flash_dq_oe ? flash_dq_out : ~last);
endmodule : fbs_flash_model

// [tb/tb_top.sv]
/* Self-checking bench of the erase controller: AXI4-Lite master, flash model.
   Assumes the package constants and the hand-over register map. */
`timescale 1ns/100ps
module tb_top;
	typedef struct packed {logic [2:0] k; logic [7:0] a; logic [31:0] d;} fbs_row_type;
	logic core_clk = 1'h0;
	logic reset = 1'h1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_arvalid = 1'h0;
	logic s_axi_bready = 1'h1, s_axi_rready = 1'h1; // Always ready for answers
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [20:0] flash_addr;
	logic flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe;
	logic [7:0] flash_dq_out, flash_dq_in;
	logic [5:0] lock_num = 6'h3F;                   // No block locked
	logic volt_low = 1'h0, erase_bad = 1'h0;
	int fails = 0, n_tests = 0;
	always #12.5 core_clk = ~core_clk;
	fbs_ctrl i_dut (.core_clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .irq, .flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n,
		.flash_dq_out, .flash_dq_oe, .flash_dq_in);
	fbs_flash_model i_flash (.flash_addr, .flash_ce_n, .flash_oe_n, .flash_we_n, .flash_dq_out,
		.flash_dq_oe, .flash_dq_in, .lock_num, .volt_low, .erase_bad);
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Handshakes judged at the negedge before the taking edge
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw, da, dw, tb;
		{da, dw, tb} = 3'h0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		while (!(da && dw)) begin
			@(negedge core_clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge core_clk);
			if (ta) s_axi_awvalid <= 1'h0;
			if (tw) s_axi_wvalid <= 1'h0;
			da |= ta;
			dw |= tw;
		end
		while (tb !== 1'h1) begin
			@(negedge core_clk);
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge core_clk);
		end
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d);
		logic t;
		t = 1'h0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		while (t !== 1'h1) begin
			@(negedge core_clk);
			t = s_axi_arready;
			@(posedge core_clk);
		end
		s_axi_arvalid <= 1'h0;
		t = 1'h0;
		while (t !== 1'h1) begin
			@(negedge core_clk);
			t = s_axi_rvalid;
			d = s_axi_rdata;
			@(posedge core_clk);
		end
	endtask : axr
	function automatic fbs_row_type rw(input int k, input logic [7:0] a, input logic [31:0] d);
		return {k[2:0], a, d};
	endfunction : rw
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : stop_test
	initial begin
		#400000;
		fails++;
		stop_test;
	end
	// Kinds: 0 write, 1 read, 2 refused write, 3 flash knob, 4 wait idle, 5 irq level
	initial begin
		fbs_row_type rows[$];
		logic [31:0] v;
		logic [1:0] br;
		int n;
		rows = {rw(1, 8'h00, 'h8), rw(1, 8'h0C, 'h80), rw(1, 8'h10, 0), rw(0, 8'h18, 7),
			rw(0, 8'h04, 'hE000), rw(0, 8'h00, 9), rw(4, 0, 0), rw(1, 8'h10, 1), rw(5, 0, 1),
			rw(1, 8'h0C, 'h80), rw(0, 8'h18, 0), rw(5, 0, 0), rw(0, 8'h18, 7), rw(0, 8'h14, 7),
			rw(5, 0, 0), rw(0, 8'h00, 2), rw(4, 0, 0), rw(0, 8'h04, 'hC000), rw(0, 8'h00, 4),
			rw(4, 0, 0), rw(1, 8'h08, 0), rw(0, 8'h04, 'hFFFF), rw(0, 8'h00, 4), rw(4, 0, 0),
			rw(1, 8'h08, 'hFF), rw(3, 0, 8), rw(0, 8'h14, 7), rw(0, 8'h04, 'h1ABCD),
			rw(0, 8'h00, 9), rw(4, 0, 0), rw(1, 8'h10, 3), rw(1, 8'h0C, 'h82), rw(1, 8'h1C, 2),
			rw(0, 8'h14, 7), rw(0, 8'h00, 9), rw(4, 0, 0), rw(1, 8'h10, 4), rw(0, 8'h08, 'h50),
			rw(0, 8'h00, 3), rw(4, 0, 0), rw(0, 8'h00, 5), rw(4, 0, 0), rw(1, 8'h0C, 'h80),
			rw(3, 0, 63), rw(3, 1, 1), rw(0, 8'h14, 7), rw(0, 8'h04, 'h1F0000), rw(0, 8'h00, 9),
			rw(4, 0, 0), rw(1, 8'h0C, 'h88), rw(1, 8'h10, 3), rw(3, 1, 0), rw(0, 8'h08, 'h50),
			rw(0, 8'h00, 3), rw(4, 0, 0), rw(0, 8'h00, 5), rw(4, 0, 0), rw(1, 8'h0C, 'h80),
			rw(3, 2, 1), rw(0, 8'h14, 7), rw(0, 8'h00, 9), rw(4, 0, 0), rw(1, 8'h0C, 'hA0),
			rw(1, 8'h10, 3), rw(0, 8'h14, 7), rw(0, 8'h00, 1), rw(4, 0, 0), rw(1, 8'h10, 1),
			rw(1, 8'h0C, 'hA0), rw(1, 8'h1C, 'h2A), rw(0, 8'h1C, 'hFF), rw(1, 8'h1C, 0),
			rw(3, 2, 0), rw(0, 8'h08, 'h50), rw(0, 8'h00, 3), rw(4, 0, 0), rw(0, 8'h08, 'h20),
			rw(0, 8'h00, 3), rw(4, 0, 0), rw(0, 8'h08, 0), rw(0, 8'h00, 3), rw(4, 0, 0),
			rw(0, 8'h00, 5), rw(4, 0, 0), rw(1, 8'h0C, 'hB0), rw(2, 8'h20, 0), rw(2, 8'h0C, 0),
			rw(2, 8'h10, 0), rw(1, 8'h20, 0), rw(1, 8'h18, 7)};
		repeat (10) @(posedge core_clk);
		reset <= 1'h0;
		foreach (rows[i]) begin
			case (rows[i].k)
				0, 2: begin
					axw(rows[i].a, rows[i].d, br);
					chk(br, (rows[i].k == 2) ? fbs_pkg::RESP_SLVERR : fbs_pkg::RESP_OKAY);
				end
				1: begin
					axr(rows[i].a, v);
					chk(v, rows[i].d);
					chk(s_axi_rresp, (rows[i].a > 8'h1C) ? fbs_pkg::RESP_SLVERR : fbs_pkg::RESP_OKAY);
				end
				3: begin
					if (rows[i].a == 8'h00) lock_num <= rows[i].d[5:0];
					if (rows[i].a == 8'h01) volt_low <= rows[i].d[0];
					if (rows[i].a == 8'h02) erase_bad <= rows[i].d[0];
				end
				4: begin
					n = 0;
					do begin
						axr(fbs_pkg::OFF_CTRL, v);
						n++;
					end while (v[0] !== 1'h0 && n < 500);
					chk(v[0], 1'h0);
				end
				default: begin
					@(negedge core_clk);
					chk(irq, rows[i].d[0]);
				end
			endcase
		end
		$display("row table done, %0d rows", rows.size());
		// Second reset in mid-run
		reset <= 1'h1;
		repeat (10) @(posedge core_clk);
		reset <= 1'h0;
		@(negedge core_clk);
		chk(irq, 1'h0);
		chk(flash_ce_n, 1'h1);
		axr(fbs_pkg::OFF_DEV_STAT, v);
		chk(v, 32'h80);
		axr(fbs_pkg::OFF_CTRL, v);
		chk(v, 32'h8);
		$display("reset test done");
		stop_test;
	end
endmodule : tb_top
